// ==== rtl/eewp_pkg.sv ====
// Purpose: shared constants and types of the eeprom write-protect block
// Assumes: 125 MHz system clock, serial link clocked by the host
// Notes:   opcodes compare after masking the don't-care bit 3
package eewp_pkg;

    // opcode decode, bit 3 ignored
    localparam logic [7:0] OPC_MASK              = 8'hF7;
    localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD       = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD      = 8'h01;
    localparam logic [7:0] WRITE_ARRAY_CMD       = 8'h02;

    // status byte field positions
    localparam int WRITE_BUSY_FLAG_POS  = 0;
    localparam int WRITE_LATCH_FLAG_POS = 1;
    localparam int BLOCK_PROTECT_LO_POS = 2;
    localparam int BLOCK_PROTECT_HI_POS = 3;
    localparam logic [3:0] STATUS_RSVD  = 4'h0;

    // array geometry and protection boundaries
    localparam int         ADDR_W         = 7;
    localparam logic [1:0] PROT_NONE      = 2'h0;
    localparam logic [1:0] PROT_QUARTER   = 2'h1;
    localparam logic [1:0] PROT_HALF      = 2'h2;
    localparam logic [1:0] PROT_ALL       = 2'h3;
    localparam logic [6:0] QUARTER_BASE   = 7'h60;
    localparam logic [6:0] HALF_BASE      = 7'h40;

    // frame lengths in whole bytes (saturating count)
    localparam logic [1:0] LATCH_FRAME_BYTES  = 2'h1;
    localparam logic [1:0] STATUS_FRAME_BYTES = 2'h2;
    localparam logic [1:0] ARRAY_FRAME_BYTES  = 2'h3;
    localparam logic [2:0] BYTE_ALIGNED       = 3'h0;
    localparam logic [2:0] LAST_BIT_IDX       = 3'h7;

    // self-timed write cycle, a longest time so it rounds down
    localparam int WRITE_TIME_US = 5000;
    localparam int CLK_FREQ_MHZ  = 125;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_FREQ_MHZ;

    // reset values
    localparam logic [1:0] BP_RESET    = 2'h0;
    localparam logic       LATCH_RESET = 1'b0;

    typedef enum logic [0:0] {
        EEWP_IDLE,
        EEWP_BUSY
    } eewp_state_t;

endpackage

// ==== rtl/eewp_link_if.sv ====
// Purpose: carrier between the serial link side and the core side
// Assumes: link fields change only while serial clock runs in a frame
// Notes:   core reads link fields only after a synchronised deselect
`timescale 1ns/100ps
interface eewp_link_if;
    logic [7:0] cmd;
    logic [7:0] arg;
    logic [7:0] data;
    logic [2:0] bit_idx;
    logic [1:0] byte_cnt;
    logic [7:0] status;
    logic       so_out;
    logic       so_oe;

    modport link (
        output cmd,
        output arg,
        output data,
        output bit_idx,
        output byte_cnt,
        output so_out,
        output so_oe,
        input  status
    );

    modport core (
        input  cmd,
        input  arg,
        input  data,
        input  bit_idx,
        input  byte_cnt,
        input  so_out,
        input  so_oe,
        output status
    );
endinterface

// ==== rtl/eewp_link.sv ====
// Purpose: serial clock domain shifter of the write-protect block
// Assumes: serial clock idles between frames, chip select active low
// Notes:   frame fields stay frozen after deselect for the core to read
`timescale 1ns/100ps
module eewp_link (
    input  wire logic   rst_b,
    input  wire logic   sck,
    input  wire logic   cs_b,
    input  wire logic   si,
    eewp_link_if.link   lk
);

    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] bit_idx;
        logic [1:0] byte_cnt;
        logic [7:0] cmd;
        logic [7:0] arg;
        logic [7:0] data;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
        logic [7:0] st_hold;
    } eewp_rx_t;

    typedef struct packed {
        logic so;
        logic oe;
    } eewp_tx_t;

    eewp_rx_t   r;
    eewp_rx_t   next_r;
    eewp_tx_t   t;
    eewp_tx_t   next_t;
    logic       frame_first;
    logic       link_clr_b;
    logic [7:0] next_byte;

    // deselect clears frame-local flops without any clock edge
    assign link_clr_b = rst_b & ~cs_b;

    // marks the first rising edge of each frame
    always_ff @(posedge sck or negedge link_clr_b) begin
        if (!link_clr_b) begin
            frame_first <= 1'b1;
        end else begin
            frame_first <= 1'b0;
        end
    end

    // receive: sample on rising edge, msb first
    always_comb begin
        next_r       = r;
        next_byte    = {r.sh[6:0], si};
        next_r.sh    = next_byte;
        next_r.st_s1 = lk.status;
        next_r.st_s2 = r.st_s1;
        if (frame_first) begin
            next_r.bit_idx  = 3'h1;
            next_r.byte_cnt = 2'h0;
        end else begin
            next_r.bit_idx = r.bit_idx + 3'h1;
            if (r.bit_idx == eewp_pkg::LAST_BIT_IDX) begin
                // status reloads at every byte, so it repeats
                next_r.st_hold = r.st_s2;
                unique case (r.byte_cnt)
                    2'h0: next_r.cmd  = next_byte;
                    2'h1: next_r.arg  = next_byte;
                    2'h2: next_r.data = next_byte;
                    2'h3: next_r.data = r.data;
                endcase
                if (r.byte_cnt != eewp_pkg::ARRAY_FRAME_BYTES) begin
                    next_r.byte_cnt = r.byte_cnt + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // transmit: status bits change after falling edge, msb first
    always_comb begin
        next_t = t;
        if (((r.cmd & eewp_pkg::OPC_MASK) == eewp_pkg::READ_STATUS_CMD)
            && (r.byte_cnt != 2'h0)) begin
            next_t.oe = 1'b1;
            next_t.so = r.st_hold[3'h7 - r.bit_idx];
        end
    end

    // high impedance whenever deselected or in reset
    always_ff @(negedge sck or negedge link_clr_b) begin
        if (!link_clr_b) begin
            t <= '0;
        end else begin
            t <= next_t;
        end
    end

    assign lk.cmd      = r.cmd;
    assign lk.arg      = r.arg;
    assign lk.data     = r.data;
    assign lk.bit_idx  = r.bit_idx;
    assign lk.byte_cnt = r.byte_cnt;
    assign lk.so_out   = t.so;
    assign lk.so_oe    = t.oe;

endmodule

// ==== rtl/eewp_core.sv ====
// Purpose: write enable latch, status byte and array protection logic
// Assumes: frame fields from the link are frozen once deselect is seen
// Notes:   one self-timed cycle serves status and array writes alike
`timescale 1ns/100ps

// Notes on behaviour
// - no write without latch set at request
// - set command sets, clear command clears latch
// - latch clears at reset, writes, protect pin low
// - status readable anytime, even while busy
// - status bit 0 reads busy flag
// - status bit 1 mirrors the write latch
// - latch commands work despite status protection
// - bits 2-3 block protect, nonvolatile, status write only
// - codes protect none, 60-7F, 40-7F, all
// - pin low or latch clear locks everything
// - write starts only on byte-aligned deselect
// - array access ignored while write runs
// - powers up idle, output off, latch clear
// - latch opcodes decoded with bit 3 ignored
// - all fields shifted msb first
// - sample on rise, drive after fall
module eewp_core #(
    parameter int WRITE_CYCLES = eewp_pkg::WRITE_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       sck,
    input  wire logic       cs_b,
    input  wire logic       si,
    output logic            so_out,
    output logic            so_oe,
    input  wire logic       wp_b,
    input  wire logic [1:0] nv_bp_in,
    output logic [1:0]      nv_bp_out,
    output logic            nv_bp_write,
    output logic            array_write_start,
    output logic [6:0]      array_write_addr,
    output logic [7:0]      array_write_data,
    output logic            array_access_en,
    output logic            write_busy
);

    localparam int TMR_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WRITE_CYCLES - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO = '0;

    typedef struct packed {
        logic                  cs_s1;
        logic                  cs_s2;
        logic                  cs_s3;
        logic                  wp_s1;
        logic                  wp_s2;
        logic                  loaded;
        logic                  latch;
        logic [1:0]            bp;
        eewp_pkg::eewp_state_t state;
        logic                  kind_status;
        logic [1:0]            new_bp;
        logic [TMR_W-1:0]      timer;
        logic                  start;
        logic [6:0]            waddr;
        logic [7:0]            wdata;
        logic                  nv_write;
    } eewp_core_t;

    // reset image: idle, deselected, latch clear; constants only
    localparam eewp_core_t CORE_RESET = '{
        cs_s1:   1'b1,
        cs_s2:   1'b1,
        cs_s3:   1'b1,
        latch:   eewp_pkg::LATCH_RESET,
        bp:      eewp_pkg::BP_RESET,
        state:   eewp_pkg::EEWP_IDLE,
        default: '0
    };

    eewp_core_t  r;
    eewp_core_t  next_r;
    eewp_link_if lk ();

    logic       deselect;
    logic       aligned;
    logic [7:0] op;
    logic       is_set;
    logic       is_clear;
    logic       is_status_wr;
    logic       is_array_wr;
    logic       writes_open;
    logic       addr_locked;
    logic       busy;

    // serial side lives on the host clock
    eewp_link u_link (
        .rst_b (rst_b),
        .sck   (sck),
        .cs_b  (cs_b),
        .si    (si),
        .lk    (lk)
    );

    // address lock per block-protect code
    function automatic logic prot_hit(
        input logic [1:0] code,
        input logic [6:0] addr
    );
        logic hit;
        hit = 1'b0;
        unique case (code)
            eewp_pkg::PROT_NONE:    hit = 1'b0;
            eewp_pkg::PROT_QUARTER: hit = addr >= eewp_pkg::QUARTER_BASE;
            eewp_pkg::PROT_HALF:    hit = addr >= eewp_pkg::HALF_BASE;
            eewp_pkg::PROT_ALL:     hit = 1'b1;
        endcase
        return hit;
    endfunction

    // frame decode, valid only in the deselect cycle
    always_comb begin
        busy     = (r.state == eewp_pkg::EEWP_BUSY);
        deselect = r.cs_s2 & ~r.cs_s3;
        aligned  = (lk.bit_idx == eewp_pkg::BYTE_ALIGNED);
        op       = lk.cmd & eewp_pkg::OPC_MASK;
        is_set   = deselect && aligned
                   && (lk.byte_cnt == eewp_pkg::LATCH_FRAME_BYTES)
                   && (op == eewp_pkg::SET_WRITE_LATCH_CMD);
        is_clear = deselect && aligned
                   && (lk.byte_cnt == eewp_pkg::LATCH_FRAME_BYTES)
                   && (op == eewp_pkg::CLEAR_WRITE_LATCH_CMD);
        // a frame cut short mid-byte never matches, so it is abandoned
        is_status_wr = deselect && aligned
                   && (lk.byte_cnt == eewp_pkg::STATUS_FRAME_BYTES)
                   && (op == eewp_pkg::WRITE_STATUS_CMD);
        // array writes of three or more whole bytes match; bytes after the data byte are dropped
        is_array_wr = deselect && aligned
                   && (lk.byte_cnt == eewp_pkg::ARRAY_FRAME_BYTES)
                   && (op == eewp_pkg::WRITE_ARRAY_CMD);
        // pin high and latch set open both status and free blocks
        writes_open = r.wp_s2 && r.latch;
        addr_locked = prot_hit(r.bp, lk.arg[6:0]);
    end

    // core state update
    always_comb begin
        next_r          = r;
        next_r.cs_s1    = cs_b;
        next_r.cs_s2    = r.cs_s1;
        next_r.cs_s3    = r.cs_s2;
        next_r.wp_s1    = wp_b;
        next_r.wp_s2    = r.wp_s1;
        next_r.start    = 1'b0;
        next_r.nv_write = 1'b0;

        // protect bits come back from storage once after reset
        if (!r.loaded) begin
            next_r.bp     = nv_bp_in;
            next_r.loaded = 1'b1;
        end

        unique case (r.state)
            eewp_pkg::EEWP_IDLE: begin
                // latch sampled as it stands when the write is asked
                if (is_status_wr && writes_open) begin
                    next_r.state       = eewp_pkg::EEWP_BUSY;
                    next_r.kind_status = 1'b1;
                    next_r.new_bp      = {
                        lk.arg[eewp_pkg::BLOCK_PROTECT_HI_POS],
                        lk.arg[eewp_pkg::BLOCK_PROTECT_LO_POS]
                    };
                    next_r.timer       = TMR_LOAD;
                end else if (is_array_wr && writes_open
                             && !addr_locked) begin
                    next_r.state       = eewp_pkg::EEWP_BUSY;
                    next_r.kind_status = 1'b0;
                    next_r.waddr       = lk.arg[6:0];
                    next_r.wdata       = lk.data;
                    next_r.start       = 1'b1;
                    next_r.timer       = TMR_LOAD;
                end
            end
            eewp_pkg::EEWP_BUSY: begin
                // new write frames are dropped until the cycle ends
                if (r.timer == TMR_ZERO) begin
                    next_r.state = eewp_pkg::EEWP_IDLE;
                    next_r.latch = 1'b0;
                    if (r.kind_status) begin
                        next_r.bp       = r.new_bp;
                        next_r.nv_write = 1'b1;
                    end
                end else begin
                    next_r.timer = r.timer - 1'b1;
                end
            end
        endcase

        // latch commands bypass status protection; placed after the
        // end-of-write clear so a set in that same cycle wins
        if (is_set) begin
            next_r.latch = 1'b1;
        end
        if (is_clear) begin
            next_r.latch = 1'b0;
        end

        // protect pin low holds the latch clear, winning over set
        if (!r.wp_s2) begin
            next_r.latch = 1'b0;
        end
    end

    // one register stage holds all core state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= CORE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // status byte sent to the link; reserved bits read as zero
    assign lk.status = {
        eewp_pkg::STATUS_RSVD,
        r.bp[1],
        r.bp[0],
        r.latch,
        busy
    };

    // outputs; serial output enable only inside a status read
    assign so_out            = lk.so_out;
    assign so_oe             = lk.so_oe;
    assign nv_bp_out         = r.bp;
    assign nv_bp_write       = r.nv_write;
    assign array_write_start = r.start;
    assign array_write_addr  = r.waddr;
    assign array_write_data  = r.wdata;
    assign array_access_en   = ~busy;
    assign write_busy        = busy;

endmodule

// ==== bench/eewp_core_assertions.sv ====
// Purpose: concurrent checks on the write-protect core ports
// Assumes: one clk_sys domain, async active low reset
// Notes:   busy length is counted in helper logic
`timescale 1ns/100ps
module eewp_core_chk #(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       cs_b,
    input wire logic       so_oe,
    input wire logic       wp_b,
    input wire logic [1:0] nv_bp_out,
    input wire logic       nv_bp_write,
    input wire logic       array_write_start,
    input wire logic [6:0] array_write_addr,
    input wire logic       array_access_en,
    input wire logic       write_busy
);
    int busy_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // busy cycles counted, zero while idle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            busy_cnt <= 0;
        else
            busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
    // start address must lie outside the protected range
    function automatic logic ok(input logic [1:0] c, input logic [6:0] a);
        return c == 2'h0 || (c == 2'h1 && a < 7'h60)
            || (c == 2'h2 && a < 7'h40);
    endfunction
    sequence wp_low_s;
        !wp_b [*8];
    endsequence
    sequence busy_rise_s;
        !$past(write_busy) ##1 write_busy;
    endsequence
    busy_len_a: assert property (
        $fell(write_busy) |-> busy_cnt == WRITE_CYCLES)
        else $error("busy length wrong");
    start_idle_a: assert property (
        array_write_start |-> busy_rise_s)
        else $error("start while busy or no busy");
    start_pulse_a: assert property (
        array_write_start |=> !array_write_start)
        else $error("start longer than one cycle");
    access_busy_a: assert property (
        array_access_en != write_busy)
        else $error("access enable not inverse of busy");
    prot_map_a: assert property (
        array_write_start |-> ok(nv_bp_out, array_write_addr))
        else $error("write started in protected block");
    wp_block_a: assert property (
        wp_low_s |-> !array_write_start)
        else $error("write started with protect pin low");
    bp_commit_a: assert property (
        $past(rst_b, 2) && $changed(nv_bp_out) |-> nv_bp_write)
        else $error("protect bits changed without commit");
    nv_end_a: assert property (
        nv_bp_write |-> $past(write_busy) || $past(write_busy, 2))
        else $error("commit not at end of busy");
    so_off_a: assert property (
        cs_b |-> !so_oe)
        else $error("serial output driven while deselected");
endmodule
bind eewp_core eewp_core_chk #(
    .WRITE_CYCLES(WRITE_CYCLES)
) i_eewp_core_chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cs_b(cs_b),
    .so_oe(so_oe),
    .wp_b(wp_b),
    .nv_bp_out(nv_bp_out),
    .nv_bp_write(nv_bp_write),
    .array_write_start(array_write_start),
    .array_write_addr(array_write_addr),
    .array_access_en(array_access_en),
    .write_busy(write_busy)
);

// ==== bench/eewp_host_model.sv ====
// Purpose: spi host model on the serial link of the core
// Assumes: mode 0, msb first, sck still outside frames
// Notes:   stretch slows each bit to act as a slow host
`timescale 1ns/100ps
module eewp_host_model (
    input  wire logic clk_sys,
    input  wire logic so_out,
    output logic      sck,
    output logic      cs_b,
    output logic      si
);
    int stretch = 0;
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        si = 1'b0;
    end
    // one frame; rx keeps the last eight bits seen
    task automatic xfer(input logic [31:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(negedge clk_sys);
        #3;
        cs_b = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si = tx[31-i];
            #(24 + stretch);
            sck = 1'b1;
            rx = {rx[6:0], so_out};
            #24;
            sck = 1'b0;
        end
        #24;
        cs_b = 1'b1;
        si = ~si; // released line must not look held
        repeat (12) @(negedge clk_sys);
    endtask
endmodule

// ==== bench/eewp_core_tb.sv ====
// Purpose: self-checking bench of the write-protect core
// Assumes: short write cycle, host model drives the link
// Notes:   expectations come from local functions, literals and bench-held values
`timescale 1ns/100ps
module eewp_core_tb;
    localparam int WC = 500;
    logic       clk_sys, rst_b, wp_b, sck, cs_b, si, so_out, so_oe;
    logic       nv_bp_write, array_write_start, array_access_en;
    logic       write_busy;
    logic [1:0] nv_bp_in, nv_bp_out, bp;
    logic [6:0] array_write_addr, a, ea;
    logic [7:0] array_write_data, rx, ed;
    int         n_mismatch = 0;
    int         tests_run = 0;
    int         n_start = 0;
    int         n_commit = 0;
    int         n_prev;

    eewp_core #(.WRITE_CYCLES(WC)) i_eewp_core (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sck(sck),
        .cs_b(cs_b),
        .si(si),
        .so_out(so_out),
        .so_oe(so_oe),
        .wp_b(wp_b),
        .nv_bp_in(nv_bp_in),
        .nv_bp_out(nv_bp_out),
        .nv_bp_write(nv_bp_write),
        .array_write_start(array_write_start),
        .array_write_addr(array_write_addr),
        .array_write_data(array_write_data),
        .array_access_en(array_access_en),
        .write_busy(write_busy)
    );
    eewp_host_model i_eewp_host_model (
        .clk_sys(clk_sys),
        .so_out(so_out),
        .sck(sck),
        .cs_b(cs_b),
        .si(si)
    );

    // expected status byte and protection map
    function automatic logic [7:0] st(input logic [1:0] b, input logic l,
                                      input logic bz);
        return {4'h0, b, l, bz};
    endfunction
    function automatic logic may(input logic [1:0] b, input logic [6:0] x);
        return b == 2'h0 || (b == 2'h1 && x < 7'h60)
            || (b == 2'h2 && x < 7'h40);
    endfunction
    task automatic chk_status(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t status %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_write(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t write %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int n);
        i_eewp_host_model.xfer({op, 24'h0}, n, rx);
    endtask
    task automatic rd_st(input logic [7:0] exp);
        cmd(eewp_pkg::READ_STATUS_CMD, 16);
        chk_status(rx, exp);
    endtask
    task automatic wr_st(input logic [1:0] b);
        i_eewp_host_model.xfer({eewp_pkg::WRITE_STATUS_CMD, 4'h0, b, 18'h0},
                               16, rx);
    endtask
    // refused writes must leave the start registers alone
    task automatic arr_wr(input logic [6:0] x, input int n, input logic ok);
        int         n0;
        logic [7:0] d;
        n0 = n_start;
        d = 8'($urandom);
        i_eewp_host_model.xfer({eewp_pkg::WRITE_ARRAY_CMD, 1'b0, x, d, 8'h0},
                               n, rx);
        if (ok) begin
            ea = x;
            ed = d;
        end
        chk_write({n_start == n0 + 1, array_write_addr, array_write_data},
                  {ok, ea, ed});
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 2000 && write_busy !== 1'b0; i++)
            @(posedge clk_sys);
        @(negedge clk_sys);
        chk_status({7'h0, write_busy}, 8'h00);
        chk_status({7'h0, array_access_en}, 8'h01);
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // clock and pulse counter
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk_sys) begin
        if (array_write_start === 1'b1)
            n_start++;
        if (nv_bp_write === 1'b1)
            n_commit++;
    end
    // hang guard, about three times the expected run time
    initial begin
        #600000;
        n_mismatch++;
        $display("Error %0t watchdog expired", $time);
        finish_test;
    end
    // main sequence
    initial begin
        void'($urandom(32'hf700));
        rst_b = 1'b0;
        wp_b = 1'b1;
        nv_bp_in = 2'($urandom);
        ea = 7'h00;
        ed = 8'h00;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        bp = nv_bp_in;
        repeat (2) @(negedge clk_sys);
        chk_status({6'h0, nv_bp_out}, {6'h0, bp});
        chk_status({7'h0, so_oe}, 8'h00);
        rd_st(st(bp, 1'b0, 1'b0));
        end_test("power_on");
        for (int k = 0; k < 4; k++) begin
            cmd(eewp_pkg::SET_WRITE_LATCH_CMD | {k[0], 3'h0}, 8);
            rd_st(st(bp, 1'b1, 1'b0));
            cmd(eewp_pkg::CLEAR_WRITE_LATCH_CMD | {k[1], 3'h0}, 8);
            rd_st(st(bp, 1'b0, 1'b0));
        end
        cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 9);
        rd_st(st(bp, 1'b0, 1'b0));
        end_test("latch");
        cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
        wp_b = 1'b0;
        rd_st(st(bp, 1'b0, 1'b0));
        cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
        arr_wr(7'h00, 24, 1'b0);
        wr_st(~bp);
        wait_idle;
        wp_b = 1'b1;
        rd_st(st(bp, 1'b0, 1'b0));
        arr_wr(7'h00, 24, 1'b0);
        end_test("protect_pin");
        for (int c = 0; c < 4; c++) begin
            cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
            n_prev = n_commit;
            wr_st(2'(c + 1));
            rd_st(st(bp, 1'b1, 1'b1));
            wait_idle;
            bp = 2'(c + 1);
            chk_status({6'h0, nv_bp_out}, {6'h0, bp});
            rd_st(st(bp, 1'b0, 1'b0));
            chk_status(8'(n_commit - n_prev), 8'h01);
            for (int q = 0; q < 8; q++) begin
                a = (q[1] ? 7'h5F : 7'h3F) + 7'(q[0]);
                if (q > 3)
                    a = {q[1:0], 5'($urandom)};
                cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
                arr_wr(a, 24, may(bp, a));
                wait_idle;
            end
        end
        wr_st(2'h3);
        wait_idle;
        rd_st(st(bp, 1'b0, 1'b0));
        end_test("block_protect");
        i_eewp_host_model.stretch = 40;
        cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
        arr_wr(7'h10, 23, 1'b0);
        arr_wr(7'h10, 25, 1'b0);
        arr_wr(7'h10, 32, 1'b1);
        wait_idle;
        i_eewp_host_model.stretch = 0;
        end_test("framing");
        cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
        arr_wr(7'h11, 24, 1'b1);
        chk_status({7'h0, array_access_en}, 8'h00);
        cmd(eewp_pkg::SET_WRITE_LATCH_CMD, 8);
        rd_st(st(bp, 1'b1, 1'b1));
        arr_wr(7'h22, 24, 1'b0);
        wait_idle;
        rd_st(st(bp, 1'b0, 1'b0));
        end_test("busy");
        finish_test;
    end
endmodule
